// *** current_supervisor_pkg.sv ***
/*
  package for the output current supervisor: command codes, field
  positions, reset values, time units and state encoding.
  assumes a 200 MHz system clock and a host command port that hands in
  whole 16-bit words already framed by the serial bus front end.
*/
package current_supervisor_pkg;

  // command codes of the three supervisor settings
  localparam logic [7:0] CMD_OC_WARN_THR   = 8'h4A;
  localparam logic [7:0] CMD_UC_FAULT_THR  = 8'h4B;
  localparam logic [7:0] CMD_UC_ACTION_CFG = 8'h4C;

  // reset values (thresholds are linear-format words)
  localparam logic [15:0] OC_WARN_THR_RST  = 16'h7BFF;
  localparam logic [15:0] UC_FAULT_THR_RST = 16'h0000;
  localparam logic [7:0]  UC_ACTION_RST    = 8'h00;

  // field positions inside the action setting
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  // response field codes
  localparam logic [1:0] RESP_IGNORE      = 2'h0;
  localparam logic [1:0] RESP_DELAYED     = 2'h1;
  localparam logic [1:0] RESP_SHUTDOWN    = 2'h2;
  localparam logic [1:0] RESP_HOLD_WHILE  = 2'h3;

  // retry field codes
  localparam logic [2:0] RETRY_NONE       = 3'h0;
  localparam logic [2:0] RETRY_FOREVER    = 3'h7;

  // linear format layout
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_FRAC    = 16;

  // time units, in ns, and their cycle counts at the system clock
  localparam longint CLK_PERIOD_NS      = 5;
  localparam longint DELAY_UNIT_NS      = 10_000_000;
  localparam longint RETRY_UNIT_NS      = 8_200_000;
  localparam int     DELAY_UNIT_CYCLES  = int'(DELAY_UNIT_NS / CLK_PERIOD_NS);
  localparam int     RETRY_UNIT_CYCLES  = int'(RETRY_UNIT_NS / CLK_PERIOD_NS);

  // supervisor sequencing states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_DELAY,
    ST_OFF_WAIT,
    ST_RETRY,
    ST_LATCHED,
    ST_HOLD
  } sup_state_e;

endpackage

// *** output_current_fault_supervisor.sv ***
/*
  output current supervisor: holds the warning and undercurrent
  thresholds and the undercurrent action setting, compares the measured
  current, and sequences ignore / delayed / shutdown-retry / hold-off.
  assumes the measured current arrives as a linear-format word synchronous
  to clk_sys_i, and that on_cmd_i is the combined control pin and
  operation command level. bias loss is seen as rst_n_i.
*/
`timescale 1ns/100ps

module output_current_fault_supervisor #(
  parameter int DELAY_UNIT_CYC = current_supervisor_pkg::DELAY_UNIT_CYCLES,
  parameter int RETRY_UNIT_CYC = current_supervisor_pkg::RETRY_UNIT_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // host command port
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic        cmd_wr_i,
  input  wire logic [15:0] cmd_wdata_i,
  input  wire logic        cmd_rd_i,
  output logic      [15:0] cmd_rdata_o,
  // fault clearing
  input  wire logic        clear_faults_i,
  input  wire logic [1:0]  status_clear_i,
  // power stage
  input  wire logic        on_cmd_i,
  input  wire logic [15:0] iout_meas_i,
  output logic             output_enable_o,
  // status and alert
  output logic             uc_fault_status_o,
  output logic             oc_warn_status_o,
  output logic             alert_output_line_n_o
);
  import current_supervisor_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic [15:0] oc_warn_thr;   // warning threshold
    logic [15:0] uc_thr;        // undercurrent threshold
    logic [7:0]  action_cfg;    // response, retry, delay fields
    sup_state_e  state;         // sequencer state
    logic [31:0] presc;         // cycles inside the current unit
    logic [2:0]  units;         // whole units elapsed
    logic [2:0]  tries;         // restart attempts made
    logic        uc_stat;       // sticky undercurrent status
    logic        oc_stat;       // sticky warning status
    logic        on_prev;       // on command last cycle
    logic        out_en;        // output enable
    logic        alert_n;       // alert line, low active
    logic [15:0] rdata;         // read return word
  } sup_s;

  sup_s state_r;   // registered state
  sup_s state_nxt; // next state

  // linear word to signed fixed point with 16 fraction bits; the
  // exponent is biased so the shift is never negative
  function automatic logic signed [47:0] lin_value(input logic [15:0] w);
    logic signed [47:0] mant;
    logic signed [5:0]  shamt;
    mant  = 48'(signed'(w[LIN_EXP_LSB-1:0]));
    shamt = 6'(signed'(w[15:LIN_EXP_LSB])) + 6'(LIN_FRAC);
    return mant <<< shamt;
  endfunction

  // compare current against both thresholds
  logic uc_now;   // undercurrent present
  logic oc_now;   // overcurrent warning present
  assign uc_now = lin_value(iout_meas_i) < lin_value(state_r.uc_thr);
  assign oc_now = lin_value(iout_meas_i) > lin_value(state_r.oc_warn_thr);

  // action fields
  logic [1:0] resp_f;   // response mode
  logic [2:0] retry_f;  // retry setting
  logic [2:0] delay_f;  // delay count
  assign resp_f  = state_r.action_cfg[RESP_MSB:RESP_LSB];
  assign retry_f = state_r.action_cfg[RETRY_MSB:RETRY_LSB];
  assign delay_f = state_r.action_cfg[DELAY_MSB:DELAY_LSB];

  // events that clear a latched fault
  logic on_rise;   // off-then-on cycle completed
  logic uc_clear;  // undercurrent status cleared this cycle
  assign on_rise  = on_cmd_i && !state_r.on_prev;
  assign uc_clear = clear_faults_i || status_clear_i[0] || on_rise;

  // unit timer: the field value is a count of units, not a power of
  // two, so a count of zero expires on the entry cycle
  logic unit_tick;     // last cycle of a unit
  logic timer_done;    // programmed number of units elapsed
  logic [31:0] unit_len;
  always_comb begin
    // the delay state uses the 10 ms unit, restart spacing the 8.2 ms one
    if (state_r.state == ST_DELAY) begin
      unit_len = 32'(DELAY_UNIT_CYC);
    end else begin
      unit_len = 32'(RETRY_UNIT_CYC);
    end
    unit_tick  = state_r.presc == unit_len - 32'h00000001;
    timer_done = state_r.units == delay_f;
  end

  // next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.on_prev = on_cmd_i;

    // settings writes from the host
    if (cmd_wr_i) begin
      unique case (cmd_code_i)
        CMD_OC_WARN_THR:   state_nxt.oc_warn_thr = cmd_wdata_i;
        CMD_UC_FAULT_THR:  state_nxt.uc_thr = cmd_wdata_i;
        CMD_UC_ACTION_CFG: state_nxt.action_cfg = cmd_wdata_i[7:0];
        default: ;
      endcase
    end

    // read mux; unmapped codes return zero
    if (cmd_rd_i) begin
      unique case (cmd_code_i)
        CMD_OC_WARN_THR:   state_nxt.rdata = state_r.oc_warn_thr;
        CMD_UC_FAULT_THR:  state_nxt.rdata = state_r.uc_thr;
        CMD_UC_ACTION_CFG: state_nxt.rdata = {8'h00, state_r.action_cfg};
        default:           state_nxt.rdata = 16'h0000;
      endcase
    end

    // sticky status: a new fault in the clearing cycle wins
    if (uc_clear) begin
      state_nxt.uc_stat = 1'b0;
    end
    if (clear_faults_i || status_clear_i[1]) begin
      state_nxt.oc_stat = 1'b0;
    end
    if (uc_now) begin
      state_nxt.uc_stat = 1'b1;
    end
    if (oc_now) begin
      state_nxt.oc_stat = 1'b1;
    end
    state_nxt.alert_n = !(state_nxt.uc_stat || state_nxt.oc_stat);

    // unit timer advances every cycle, restarted on state change below
    if (unit_tick) begin
      state_nxt.presc = 32'h00000000;
      if (!timer_done) begin
        state_nxt.units = state_r.units + 3'h1;
      end
    end else begin
      state_nxt.presc = state_r.presc + 32'h00000001;
    end

    // sequencer
    unique case (state_r.state)
      ST_RUN: begin
        if (uc_now && on_cmd_i) begin
          state_nxt.tries = 3'h0;
          unique case (resp_f)
            RESP_IGNORE:     ;
            RESP_DELAYED:    state_nxt.state = ST_DELAY;
            RESP_SHUTDOWN:   state_nxt.state = ST_OFF_WAIT;
            RESP_HOLD_WHILE: state_nxt.state = ST_HOLD;
          endcase
          if (resp_f == RESP_SHUTDOWN && retry_f == RETRY_NONE) begin
            state_nxt.state = ST_LATCHED;
          end
        end
      end
      ST_DELAY: begin
        // output keeps running for the delay, then retry setting applies
        if (!uc_now) begin
          state_nxt.state = ST_RUN;
        end else if (timer_done) begin
          if (retry_f == RETRY_NONE) begin
            state_nxt.state = ST_LATCHED;
          end else begin
            state_nxt.state = ST_OFF_WAIT;
          end
        end
      end
      ST_OFF_WAIT: begin
        // output off; next attempt starts one interval after the last
        if (!on_cmd_i) begin
          state_nxt.state = ST_RUN;
        end else if (timer_done) begin
          state_nxt.state = ST_RETRY;
          state_nxt.tries = state_r.tries + 3'h1;
        end
      end
      ST_RETRY: begin
        // attempt counts as good if the fault stays away one interval
        if (!on_cmd_i) begin
          state_nxt.state = ST_RUN;
        end else if (uc_now) begin
          if (retry_f != RETRY_FOREVER && state_r.tries >= retry_f) begin
            state_nxt.state = ST_LATCHED;
          end else begin
            state_nxt.state = ST_OFF_WAIT;
          end
        end else if (timer_done) begin
          state_nxt.state = ST_RUN;
        end
      end
      ST_LATCHED: begin
        // stays off until the fault is cleared by any means
        if (uc_clear) begin
          state_nxt.state = ST_RUN;
        end
      end
      ST_HOLD: begin
        // resumes by itself once the fault is gone
        if (!uc_now) begin
          state_nxt.state = ST_RUN;
        end
      end
      default: state_nxt.state = ST_RUN;
    endcase

    // a state change restarts the unit timer
    if (state_nxt.state != state_r.state) begin
      state_nxt.presc = 32'h00000000;
      state_nxt.units = 3'h0;
    end

    // output stays on in run, delay and retry while commanded on
    state_nxt.out_en = on_cmd_i && (state_nxt.state == ST_RUN ||
                                    state_nxt.state == ST_DELAY ||
                                    state_nxt.state == ST_RETRY);
  end

  // register the whole state
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r             <= '0;
      state_r.oc_warn_thr <= OC_WARN_THR_RST;
      state_r.uc_thr      <= UC_FAULT_THR_RST;
      state_r.action_cfg  <= UC_ACTION_RST;
      state_r.state       <= ST_RUN;
      state_r.alert_n     <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from flip-flops
  assign cmd_rdata_o           = state_r.rdata;
  assign output_enable_o       = state_r.out_en;
  assign uc_fault_status_o     = state_r.uc_stat;
  assign oc_warn_status_o      = state_r.oc_stat;
  assign alert_output_line_n_o = state_r.alert_n;

endmodule

// *** supervisor_sva.sv ***
/* port checker for the output current supervisor.
   assumes its unit counts match the bound instance and a host that
   pulses one strobe per register access. */
`timescale 1ns/100ps
module supervisor_sva #(
  parameter int DELAY_UNIT_CYC = 10,
  parameter int RETRY_UNIT_CYC = 8
) (
  // clock, reset and host port
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  cmd_code_i,
  input wire logic        cmd_wr_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic        cmd_rd_i,
  input wire logic [15:0] cmd_rdata_o,
  // power stage and status
  input wire logic        on_cmd_i,
  input wire logic        output_enable_o,
  input wire logic        uc_fault_status_o,
  input wire logic        oc_warn_status_o,
  input wire logic        alert_output_line_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0]  cfg_r;     // shadow of the action setting
  logic [31:0] off_cnt_r; // cycles the output has stood off
  // shadow follows host writes on the same edge as the design does
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r     <= 8'h00;
      off_cnt_r <= 32'h0;
    end else begin
      if (cmd_wr_i && cmd_code_i == 8'h4C) begin
        cfg_r <= cmd_wdata_i[7:0];
      end
      off_cnt_r <= output_enable_o ? 32'h0 : off_cnt_r + 32'h1;
    end
  end
  sequence s_uc_wr;
    cmd_wr_i && cmd_code_i == 8'h4B;
  endsequence
  sequence s_uc_rd;
    cmd_rd_i && !cmd_wr_i && cmd_code_i == 8'h4B;
  endsequence
  property p_alert;
    alert_output_line_n_o == !(uc_fault_status_o || oc_warn_status_o);
  endproperty
  // the word written three edges before the answer must come back
  property p_uc_rw;
    s_uc_wr ##2 s_uc_rd |=> cmd_rdata_o == $past(cmd_wdata_i, 3);
  endproperty
  property p_cfg_hi;
    cmd_rd_i && cmd_code_i == 8'h4C |=> cmd_rdata_o[15:8] == 8'h00;
  endproperty
  property p_unmap;
    cmd_rd_i && !(cmd_code_i inside {8'h4A, 8'h4B, 8'h4C}) |=> cmd_rdata_o == 16'h0000;
  endproperty
  property p_rd_hold;
    !cmd_rd_i |=> $stable(cmd_rdata_o);
  endproperty
  property p_off_cmd;
    !on_cmd_i |=> !output_enable_o;
  endproperty
  property p_ignore;
    cfg_r[7:6] == 2'h0 && output_enable_o && on_cmd_i |=> output_enable_o;
  endproperty
  property p_shut;
    $rose(uc_fault_status_o) && cfg_r[7:6] == 2'h2 |-> !output_enable_o;
  endproperty
  // the shortest delay is one unit, so five cycles of grace always hold
  property p_delay;
    $rose(uc_fault_status_o) && cfg_r[7:6] == 2'h1 && cfg_r[2:0] != 3'h0
      && output_enable_o && on_cmd_i |-> output_enable_o [*5];
  endproperty
  property p_retry_gap;
    $rose(output_enable_o) && cfg_r[7:3] == 5'h17 && $past(on_cmd_i, 2)
      |-> off_cnt_r >= RETRY_UNIT_CYC * cfg_r[2:0];
  endproperty
  a_alert: assert property (p_alert) else $error("alert disagrees with status");
  a_uc_rw: assert property (p_uc_rw) else $error("uc threshold readback wrong");
  a_cfg_hi: assert property (p_cfg_hi) else $error("action upper byte not zero");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_rd_hold: assert property (p_rd_hold) else $error("read word moved");
  a_off_cmd: assert property (p_off_cmd) else $error("output on while off");
  a_ignore: assert property (p_ignore) else $error("ignore mode dropped output");
  a_shut: assert property (p_shut) else $error("shutdown mode left output on");
  a_delay: assert property (p_delay) else $error("delay mode cut output early");
  a_retry_gap: assert property (p_retry_gap) else $error("restart too early");
endmodule
bind output_current_fault_supervisor supervisor_sva #(
  .DELAY_UNIT_CYC(DELAY_UNIT_CYC), .RETRY_UNIT_CYC(RETRY_UNIT_CYC)) u_sva (
  .clk_sys_i, .rst_n_i, .cmd_code_i, .cmd_wr_i, .cmd_wdata_i, .cmd_rd_i,
  .cmd_rdata_o, .on_cmd_i, .output_enable_o, .uc_fault_status_o,
  .oc_warn_status_o, .alert_output_line_n_o);

// *** host_model.sv ***
/* host controller model: one-cycle write and read strobes.
   assumes the framed word port of the supervisor; drives at falling edges. */
`timescale 1ns/100ps
module host_model (
  input  wire logic        clk_sys_i,
  output logic      [7:0]  cmd_code_o,
  output logic             cmd_wr_o,
  output logic      [15:0] cmd_wdata_o,
  output logic             cmd_rd_o,
  input  wire logic [15:0] cmd_rdata_i
);
  initial begin
    cmd_code_o  = 8'h00;
    cmd_wr_o    = 1'b0;
    cmd_wdata_o = 16'h0000;
    cmd_rd_o    = 1'b0;
  end
  // write strobe stands one rising edge, then the word is scrambled
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk_sys_i);
    cmd_code_o  = code;
    cmd_wdata_o = data;
    cmd_wr_o    = 1'b1;
    @(negedge clk_sys_i);
    cmd_wr_o    = 1'b0;
    cmd_wdata_o = ~data;
  endtask
  // word is taken one edge after the read strobe is sampled
  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    @(negedge clk_sys_i);
    cmd_code_o = code;
    cmd_rd_o   = 1'b1;
    @(negedge clk_sys_i);
    cmd_rd_o   = 1'b0;
    data       = cmd_rdata_i;
  endtask
endmodule

// *** test_output_current_fault_supervisor.sv ***
/* bench for the output current supervisor: register access and fault modes.
   assumes delay and retry units shortened to 10 and 8 cycles. */
`timescale 1ns/100ps
module test_output_current_fault_supervisor;
  import current_supervisor_pkg::*;
  localparam logic [15:0] I_OK = 16'h0014; // 20 A, between both limits
  localparam logic [15:0] I_LO = 16'h0005; // 5 A, under the uc limit
  logic        clk_sys_i, rst_n_i, clear_faults_i, on_cmd_i, cmd_wr_i, cmd_rd_i;
  logic        output_enable_o, uc_fault_status_o, oc_warn_status_o, alert_output_line_n_o;
  logic [1:0]  status_clear_i;
  logic [7:0]  cmd_code_i;
  logic [15:0] iout_meas_i, cmd_wdata_i, cmd_rdata_o, v;
  int          err_total = 0, check_count = 0, cyc_count = 0, r;
  logic [7:0]  codes [4] = '{8'h4A, 8'h4B, 8'h4C, 8'h4D};
  logic [15:0] wv [4] = '{16'h001E, 16'h000A, 16'hAB80, 16'h1234};
  logic [15:0] rv [4] = '{16'h001E, 16'h000A, 16'h0080, 16'h0000};
  logic [15:0] dv [4] = '{OC_WARN_THR_RST, UC_FAULT_THR_RST, {8'h00, UC_ACTION_RST}, 16'h0000};
  host_model u_host (.clk_sys_i, .cmd_code_o(cmd_code_i), .cmd_wr_o(cmd_wr_i),
    .cmd_wdata_o(cmd_wdata_i), .cmd_rd_o(cmd_rd_i), .cmd_rdata_i(cmd_rdata_o));
  output_current_fault_supervisor #(.DELAY_UNIT_CYC(10), .RETRY_UNIT_CYC(8)) uut (
    .clk_sys_i, .rst_n_i, .cmd_code_i, .cmd_wr_i, .cmd_wdata_i, .cmd_rd_i, .cmd_rdata_o,
    .clear_faults_i, .status_clear_i, .on_cmd_i, .iout_meas_i, .output_enable_o,
    .uc_fault_status_o, .oc_warn_status_o, .alert_output_line_n_o);
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // the run needs some 500 cycles; the ceiling leaves wide room
  always @(posedge clk_sys_i) begin
    cyc_count++;
    if (cyc_count == 3000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // one-cycle clear pulse, either the global or the per-bit kind
  task automatic clr(input logic cf, input logic [1:0] sc);
    @(negedge clk_sys_i);
    clear_faults_i = cf;
    status_clear_i = sc;
    @(negedge clk_sys_i);
    clear_faults_i = 1'b0;
    status_clear_i = 2'h0;
  endtask
  // counts restarts of the output over n cycles
  task automatic rises(input int n, output int cnt);
    logic prev;
    prev = output_enable_o;
    cnt  = 0;
    repeat (n) begin
      @(negedge clk_sys_i);
      if (output_enable_o && !prev) cnt++;
      prev = output_enable_o;
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {rst_n_i, clear_faults_i, status_clear_i} = 4'h0;
    on_cmd_i    = 1'b1;
    iout_meas_i = I_OK;
    cyc(8);
    rst_n_i = 1'b1;
    cyc(2);
    check(16'(output_enable_o), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      u_host.rd(codes[i], v);
      check(v, dv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      u_host.wr(codes[i], wv[i]);
      u_host.rd(codes[i], v);
      check(v, rv[i]);
    end
    iout_meas_i = 16'h0028;
    cyc(2);
    check(16'({oc_warn_status_o, alert_output_line_n_o}), 16'h0002);
    iout_meas_i = I_OK;
    clr(1'b0, 2'h2);
    cyc(1);
    check(16'({oc_warn_status_o, alert_output_line_n_o}), 16'h0001);
    // mode shutdown, no retry: a one-cycle dip latches the output off
    iout_meas_i = I_LO;
    cyc(1);
    iout_meas_i = I_OK;
    cyc(1);
    check(16'({uc_fault_status_o, alert_output_line_n_o, output_enable_o}), 16'h0004);
    cyc(20);
    check(16'(output_enable_o), 16'h0000);
    clr(1'b1, 2'h0);
    cyc(1);
    check(16'({uc_fault_status_o, output_enable_o}), 16'h0001);
    u_host.wr(CMD_UC_ACTION_CFG, 16'h0000);
    iout_meas_i = I_LO;
    cyc(1);
    iout_meas_i = I_OK;
    cyc(1);
    check(16'({uc_fault_status_o, output_enable_o}), 16'h0003);
    clr(1'b0, 2'h1);
    u_host.wr(CMD_UC_ACTION_CFG, 16'h00C0);
    iout_meas_i = I_LO;
    cyc(4);
    check(16'(output_enable_o), 16'h0000);
    iout_meas_i = I_OK;
    cyc(3);
    check(16'(output_enable_o), 16'h0001);
    clr(1'b0, 2'h1);
    // delayed mode, two units of ten cycles
    u_host.wr(CMD_UC_ACTION_CFG, 16'h0042);
    iout_meas_i = I_LO;
    cyc(18);
    check(16'(output_enable_o), 16'h0001);
    cyc(6);
    check(16'(output_enable_o), 16'h0000);
    iout_meas_i = I_OK;
    clr(1'b1, 2'h0);
    // delayed mode, one retry: fault leaves while off, the attempt holds
    u_host.wr(CMD_UC_ACTION_CFG, 16'h0049);
    iout_meas_i = I_LO;
    cyc(14);
    check(16'(output_enable_o), 16'h0000);
    iout_meas_i = I_OK;
    cyc(20);
    check(16'({uc_fault_status_o, output_enable_o}), 16'h0003);
    clr(1'b0, 2'h1);
    u_host.wr(CMD_UC_ACTION_CFG, 16'h0091);
    iout_meas_i = I_LO;
    rises(200, r);
    check(r[15:0], 16'h0002);
    iout_meas_i = I_OK;
    on_cmd_i = 1'b0;
    cyc(3);
    on_cmd_i = 1'b1;
    cyc(3);
    check(16'(output_enable_o), 16'h0001);
    clr(1'b0, 2'h1);
    u_host.wr(CMD_UC_ACTION_CFG, 16'h00B9);
    iout_meas_i = I_LO;
    rises(100, r);
    check(16'(r > 6), 16'h0001);
    on_cmd_i = 1'b0;
    rises(30, r);
    check(r[15:0], 16'h0000);
    iout_meas_i = I_OK;
    on_cmd_i = 1'b1;
    rst_n_i = 1'b0;
    cyc(2);
    rst_n_i = 1'b1;
    u_host.rd(CMD_OC_WARN_THR, v);
    check(v, OC_WARN_THR_RST);
    complete_run();
  end
endmodule
